// ### core/sgwm_consts.vh
// Constants for the switchgear wear monitor
`ifndef SGWM_CONSTS_VH
`define SGWM_CONSTS_VH
// ****************************************
// Register map
// ****************************************
`define SGWM_OFF_CTRL 8'h00
`define SGWM_OFF_OPS_MAX 8'h04
`define SGWM_OFF_ISUM_THR 8'h08
`define SGWM_OFF_IHR_THR 8'h0C
`define SGWM_OFF_T_OPEN 8'h10
`define SGWM_OFF_T_CLOSE 8'h14
`define SGWM_OFF_NPTS 8'h18
`define SGWM_OFF_STATUS 8'h1C
`define SGWM_OFF_OPS_CNT 8'h20
`define SGWM_OFF_SUM_L1 8'h24
`define SGWM_OFF_SUM_L2 8'h28
`define SGWM_OFF_SUM_L3 8'h2C
`define SGWM_OFF_HR_SUM 8'h30
`define SGWM_OFF_WEAR 8'h34
`define SGWM_OFF_CURVE 8'h40
`define SGWM_OFF_CURVE_END 8'h68
// ****************************************
// Fields and reset values
// ****************************************
`define SGWM_CTRL_CLR 0
`define SGWM_ST_OPS 0
`define SGWM_ST_ISUM 1
`define SGWM_ST_PH 2
`define SGWM_ST_IHR 5
`define SGWM_ST_SLOW 6
`define SGWM_ST_WEAR 7
`define SGWM_ST_MAINT 8
`define SGWM_RST_OPS_MAX 32'h0000_2710
`define SGWM_RST_ISUM_THR 32'h000F_4240
`define SGWM_RST_IHR_THR 32'h0000_2710
`define SGWM_RST_T_MOVE 32'h0000_03E8
`define SGWM_RST_NPTS 4'hA
`define SGWM_NPTS_MAX 4'hA
`define SGWM_PCT_FULL 8'h64
`define SGWM_LIFE_FULL 32'h0098_9680
`define SGWM_LIFE_PER_PCT 32'h0001_86A0
// ****************************************
// Timing
// ****************************************
`define SGWM_CLK_HZ 10000000
`define SGWM_HOUR_S 3600
`define SGWM_HOUR_CYC (`SGWM_CLK_HZ * 64'd3600)
`define SGWM_MS_CYC (`SGWM_CLK_HZ / 1000)
`endif

// ### core/sgwm_curve_mem.v
// Wear curve point memory with registered read port
module sgwm_curve_mem #(
  parameter DEPTH = 10,
  parameter AW = 4
) (
  input wire clk, // System clock
  input wire rst, // Async reset, high
  input wire we, // Write strobe
  input wire [AW-1:0] waddr, // Write index
  input wire [31:0] wdata, // Point: current kA [31:16], count [15:0]
  input wire [AW-1:0] raddr, // Read index
  output reg [31:0] rdata // Registered read data
);
  reg [31:0] mem [0:DEPTH-1];
  integer i;

  // Storage; cleared at reset so the curve starts empty
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= 32'h0000_0000;
      end
      rdata <= 32'h0000_0000;
    end else begin
      if (we && (waddr < DEPTH)) begin
        mem[waddr] <= wdata;
      end
      rdata <= (raddr < DEPTH) ? mem[raddr] : 32'h0000_0000;
    end
  end
endmodule // sgwm_curve_mem

// ### core/sgwm_monitor.v
// Switchgear wear monitor top with AXI4-Lite register slave
`include "sgwm_consts.vh"
module sgwm_monitor #(
  parameter [63:0] HOUR_CYCLES = `SGWM_HOUR_CYC
) (
  input wire CLK_SYS, // System clock 10 MHz
  input wire RST, // Async reset, high
  input wire POS_ON, // Breaker closed contact
  input wire POS_OFF, // Breaker open contact
  input wire TRIP_CMD, // Open command to breaker
  input wire CLOSE_CMD, // Close command to breaker
  input wire [15:0] I_L1, // Phase 1 current, A
  input wire [15:0] I_L2, // Phase 2 current, A
  input wire [15:0] I_L3, // Phase 3 current, A
  input wire [7:0] S_AXI_AWADDR, // Write address
  input wire S_AXI_AWVALID, // Write address valid
  output reg S_AXI_AWREADY, // Write address ready
  input wire [31:0] S_AXI_WDATA, // Write data
  input wire [3:0] S_AXI_WSTRB, // Write strobes
  input wire S_AXI_WVALID, // Write data valid
  output reg S_AXI_WREADY, // Write data ready
  output reg [1:0] S_AXI_BRESP, // Write response
  output reg S_AXI_BVALID, // Write response valid
  input wire S_AXI_BREADY, // Write response ready
  input wire [7:0] S_AXI_ARADDR, // Read address
  input wire S_AXI_ARVALID, // Read address valid
  output reg S_AXI_ARREADY, // Read address ready
  output reg [31:0] S_AXI_RDATA, // Read data
  output reg [1:0] S_AXI_RRESP, // Read response
  output reg S_AXI_RVALID, // Read data valid
  input wire S_AXI_RREADY, // Read data ready
  output reg OPS_ALARM, // Operation limit alarm
  output reg ISUM_ALARM, // Current sum alarm
  output reg [2:0] PHASE_ALARM, // Per-phase current sum alarm
  output reg HOURLY_CURRENT_SUM_ALARM, // Hourly sum alarm
  output reg SLOW_SWITCHING_FLAG, // Slow switchgear
  output reg WEAR_CURVE_ALARM // Wear curve alarm
);
  localparam S_IDLE = 3'd0, S_FIND = 3'd1, S_WAIT = 3'd2, S_CALC = 3'd3, S_DIV = 3'd4;
  // ****************************************
  // Pin synchronisers
  // ****************************************
  reg [3:0] sync1_reg, sync2_reg;
  reg [47:0] isync1_reg, isync2_reg;
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      isync1_reg <= 48'h0;
      isync2_reg <= 48'h0;
    end else begin
      sync1_reg <= {CLOSE_CMD, TRIP_CMD, POS_OFF, POS_ON};
      sync2_reg <= sync1_reg;
      isync1_reg <= {I_L3, I_L2, I_L1};
      isync2_reg <= isync1_reg;
    end
  end
  wire pos_on = sync2_reg[0], pos_off = sync2_reg[1];
  wire trip = sync2_reg[2], close = sync2_reg[3];
  // ****************************************
  // Registers
  // ****************************************
  reg [31:0] ops_max_reg, isum_thr_reg, ihr_thr_reg, t_open_reg, t_close_reg, ops_cnt_reg;
  reg [31:0] hr_sum_reg, life_reg, move_tmr_reg, prev_pt_reg, allow_reg, wdata_reg, rd_mux;
  reg [31:0] sum_reg [0:2];
  reg [63:0] hr_tmr_reg;
  reg [15:0] ms_tmr_reg, ika_reg;
  reg [7:0] awaddr_reg;
  reg [3:0] npts_reg, idx_reg;
  reg [2:0] st_reg;
  reg moving_reg, opening_reg, trip_d_reg, close_d_reg, aw_hold_reg, w_hold_reg;
  wire [31:0] pt_rdata;
  // Curve write decode
  wire wr_go = aw_hold_reg && w_hold_reg && !S_AXI_BVALID;
  wire curve_hit = (awaddr_reg >= `SGWM_OFF_CURVE) && (awaddr_reg < `SGWM_OFF_CURVE_END);
  wire [7:0] cidx = (awaddr_reg - `SGWM_OFF_CURVE) >> 2;
  sgwm_curve_mem #(.DEPTH(10), .AW(4)) u_mem (
    .clk(CLK_SYS),
    .rst(RST),
    .we(wr_go && curve_hit),
    .waddr(cidx[3:0]),
    .wdata(wdata_reg),
    .raddr(idx_reg),
    .rdata(pt_rdata)
  );
  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  // Address and data latched independently, so either may arrive first
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'b00;
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0;
      ops_max_reg <= `SGWM_RST_OPS_MAX;
      isum_thr_reg <= `SGWM_RST_ISUM_THR;
      ihr_thr_reg <= `SGWM_RST_IHR_THR;
      t_open_reg <= `SGWM_RST_T_MOVE;
      t_close_reg <= `SGWM_RST_T_MOVE;
      npts_reg <= `SGWM_RST_NPTS;
    end else begin
      S_AXI_AWREADY <= !aw_hold_reg && !S_AXI_AWREADY && S_AXI_AWVALID;
      S_AXI_WREADY <= !w_hold_reg && !S_AXI_WREADY && S_AXI_WVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= S_AXI_WDATA;
      end
      if (wr_go) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= 2'b00;
        case (awaddr_reg)
          `SGWM_OFF_CTRL: ;
          `SGWM_OFF_OPS_MAX: ops_max_reg <= wdata_reg;
          `SGWM_OFF_ISUM_THR: isum_thr_reg <= wdata_reg;
          `SGWM_OFF_IHR_THR: ihr_thr_reg <= wdata_reg;
          `SGWM_OFF_T_OPEN: t_open_reg <= wdata_reg;
          `SGWM_OFF_T_CLOSE: t_close_reg <= wdata_reg;
          `SGWM_OFF_NPTS: begin
            if (wdata_reg[3:0] != 4'h0 && wdata_reg[3:0] <= `SGWM_NPTS_MAX)
              npts_reg <= wdata_reg[3:0];
          end
          default: begin
            if (!curve_hit)
              S_AXI_BRESP <= 2'b10;
          end
        endcase
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
      end
    end
  end
  // Byte strobes ignored: full-word registers only, a limitation for software
  wire clr_stats = wr_go && (awaddr_reg == `SGWM_OFF_CTRL) && wdata_reg[`SGWM_CTRL_CLR];
  // ****************************************
  // Breaker operation tracking
  // ****************************************
  wire trip_rise = trip && !trip_d_reg;
  wire close_rise = close && !close_d_reg;
  wire arrived = moving_reg && (opening_reg ? pos_off : pos_on);
  wire ms_tick = (ms_tmr_reg == (`SGWM_MS_CYC - 1));
  wire [31:0] t_limit = opening_reg ? t_open_reg : t_close_reg;
  wire [15:0] imax12 = (isync2_reg[15:0] > isync2_reg[31:16]) ? isync2_reg[15:0] :
                       isync2_reg[31:16];
  wire [15:0] imax = (imax12 > isync2_reg[47:32]) ? imax12 : isync2_reg[47:32];
  wire open_done = arrived && opening_reg;
  wire slow_set = arrived && (move_tmr_reg > t_limit) && !(trip_rise && !pos_off) &&
                  !(close_rise && !pos_on && !moving_reg); // Beats a same-cycle clear
  integer p;
  // Travel timer in ms, count updated on each finished operation, phase sums on each opening
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      trip_d_reg <= 1'b0;
      close_d_reg <= 1'b0;
      moving_reg <= 1'b0;
      opening_reg <= 1'b0;
      move_tmr_reg <= 32'h0;
      ms_tmr_reg <= 16'h0;
      ops_cnt_reg <= 32'h0;
      hr_sum_reg <= 32'h0;
      hr_tmr_reg <= 64'h0;
      SLOW_SWITCHING_FLAG <= 1'b0;
      for (p = 0; p < 3; p = p + 1) begin
        sum_reg[p] <= 32'h0;
      end
    end else begin
      trip_d_reg <= trip;
      close_d_reg <= close;
      ms_tmr_reg <= ms_tick ? 16'h0 : ms_tmr_reg + 16'h1;
      if (trip_rise && !pos_off) begin
        moving_reg <= 1'b1;
        opening_reg <= 1'b1;
        move_tmr_reg <= 32'h0;
      end else if (close_rise && !pos_on && !moving_reg) begin
        moving_reg <= 1'b1;
        opening_reg <= 1'b0;
        move_tmr_reg <= 32'h0;
      end else if (arrived) begin
        moving_reg <= 1'b0;
        ops_cnt_reg <= ops_cnt_reg + 32'h1;
        if (move_tmr_reg > t_limit) begin
          SLOW_SWITCHING_FLAG <= 1'b1;
        end
      end else if (moving_reg && ms_tick) begin
        move_tmr_reg <= move_tmr_reg + 32'h1;
      end
      // Interrupted current added when the breaker reaches open
      if (open_done) begin
        for (p = 0; p < 3; p = p + 1) begin
          sum_reg[p] <= sum_reg[p] + {16'h0, isync2_reg[p*16 +: 16]};
        end
      end
      // Hourly window restarts the sum; a current in the last cycle still lands
      if (hr_tmr_reg == HOUR_CYCLES - 64'd1) begin
        hr_tmr_reg <= 64'h0;
        hr_sum_reg <= open_done ? {16'h0, imax} : 32'h0;
      end else begin
        hr_tmr_reg <= hr_tmr_reg + 64'h1;
        if (open_done) begin
          hr_sum_reg <= hr_sum_reg + {16'h0, imax};
        end
      end
      if (clr_stats) begin
        ops_cnt_reg <= 32'h0;
        SLOW_SWITCHING_FLAG <= slow_set;
        for (p = 0; p < 3; p = p + 1) begin
          sum_reg[p] <= 32'h0;
        end
      end
    end
  end
  // ****************************************
  // Wear curve evaluation
  // ****************************************
  // Walk points until one with equal or higher current; linear step between neighbours
  wire [15:0] p_i = pt_rdata[31:16];
  wire [15:0] p_n = (idx_reg == npts_reg - 4'h1) ? 16'h0 : pt_rdata[15:0];
  wire [15:0] q_i = prev_pt_reg[31:16], q_n = prev_pt_reg[15:0];
  wire [15:0] di = p_i - q_i;
  wire [31:0] dn = (q_n > p_n) ? {16'h0, q_n - p_n} : 32'h0;
  wire [31:0] frac = (di == 16'h0) ? 32'h0 : (dn * {16'h0, ika_reg - q_i}) / {16'h0, di};
  // Zero allowance uses up the whole remaining life at once
  wire [31:0] life_step = (allow_reg == 32'h0) ? `SGWM_LIFE_FULL : `SGWM_LIFE_FULL / allow_reg;
  wire [31:0] life_sum = life_reg + life_step;
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      st_reg <= S_IDLE;
      idx_reg <= 4'h0;
      prev_pt_reg <= 32'h0;
      allow_reg <= 32'h0;
      ika_reg <= 16'h0;
      life_reg <= 32'h0;
    end else begin
      case (st_reg)
        S_IDLE: begin
          if (open_done) begin
            ika_reg <= imax / 16'd1000;
            idx_reg <= 4'h0;
            prev_pt_reg <= 32'h0;
            st_reg <= S_WAIT;
          end
        end
        S_WAIT: st_reg <= S_FIND;
        S_FIND: begin
          if (ika_reg <= p_i) begin
            st_reg <= S_CALC;
          end else if (idx_reg == npts_reg - 4'h1) begin
            allow_reg <= 32'h0;
            st_reg <= S_DIV;
          end else begin
            prev_pt_reg <= {p_i, p_n};
            idx_reg <= idx_reg + 4'h1;
            st_reg <= S_WAIT;
          end
        end
        S_CALC: begin
          allow_reg <= (idx_reg == 4'h0) ? {16'h0, p_n} : {16'h0, q_n} - frac;
          st_reg <= S_DIV;
        end
        S_DIV: begin
          // Saturate so the level never passes full scale
          life_reg <= (life_sum > `SGWM_LIFE_FULL) ? `SGWM_LIFE_FULL : life_sum;
          st_reg <= S_IDLE;
        end
        default: st_reg <= S_IDLE;
      endcase
      if (clr_stats) begin
        life_reg <= 32'h0;
      end
    end
  end
  wire [31:0] wear_pct = life_reg / `SGWM_LIFE_PER_PCT;
  // ****************************************
  // Alarms
  // ****************************************
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      OPS_ALARM <= 1'b0;
      ISUM_ALARM <= 1'b0;
      PHASE_ALARM <= 3'h0;
      HOURLY_CURRENT_SUM_ALARM <= 1'b0;
      WEAR_CURVE_ALARM <= 1'b0;
    end else begin
      OPS_ALARM <= ops_cnt_reg > ops_max_reg;
      PHASE_ALARM <= {sum_reg[2] > isum_thr_reg, sum_reg[1] > isum_thr_reg,
                      sum_reg[0] > isum_thr_reg};
      ISUM_ALARM <= (sum_reg[0] > isum_thr_reg) || (sum_reg[1] > isum_thr_reg) ||
                    (sum_reg[2] > isum_thr_reg);
      HOURLY_CURRENT_SUM_ALARM <= hr_sum_reg > ihr_thr_reg;
      WEAR_CURVE_ALARM <= wear_pct >= {24'h0, `SGWM_PCT_FULL};
    end
  end
  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  always @* begin
    rd_mux = 32'h0;
    case (S_AXI_ARADDR)
      `SGWM_OFF_OPS_MAX: rd_mux = ops_max_reg;
      `SGWM_OFF_ISUM_THR: rd_mux = isum_thr_reg;
      `SGWM_OFF_IHR_THR: rd_mux = ihr_thr_reg;
      `SGWM_OFF_T_OPEN: rd_mux = t_open_reg;
      `SGWM_OFF_T_CLOSE: rd_mux = t_close_reg;
      `SGWM_OFF_NPTS: rd_mux = {28'h0, npts_reg};
      `SGWM_OFF_STATUS: rd_mux = {23'h0, WEAR_CURVE_ALARM, WEAR_CURVE_ALARM,
        SLOW_SWITCHING_FLAG, HOURLY_CURRENT_SUM_ALARM, PHASE_ALARM, ISUM_ALARM, OPS_ALARM};
      `SGWM_OFF_OPS_CNT: rd_mux = ops_cnt_reg;
      `SGWM_OFF_SUM_L1: rd_mux = sum_reg[0];
      `SGWM_OFF_SUM_L2: rd_mux = sum_reg[1];
      `SGWM_OFF_SUM_L3: rd_mux = sum_reg[2];
      `SGWM_OFF_HR_SUM: rd_mux = hr_sum_reg;
      `SGWM_OFF_WEAR: rd_mux = wear_pct;
      default: rd_mux = 32'h0;
    endcase
  end
  wire rd_ok = (S_AXI_ARADDR <= `SGWM_OFF_WEAR) && (S_AXI_ARADDR[1:0] == 2'b00);
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= 2'b00;
    end else begin
      S_AXI_ARREADY <= 1'b0;
      if (S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID) begin
        S_AXI_ARREADY <= 1'b1;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin // Data only after address taken
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_mux;
        S_AXI_RRESP <= rd_ok ? 2'b00 : 2'b10;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end
endmodule // sgwm_monitor

// ### tb/sgwm_chk.sv
// Port-level assertion checker for the wear monitor
module sgwm_chk (
  input wire CLK_SYS, // Clock
  input wire RST, // Reset
  input wire POS_ON, // Closed contact
  input wire POS_OFF, // Open contact
  input wire [7:0] S_AXI_AWADDR, // Write addr
  input wire S_AXI_AWVALID, // AW valid
  input wire S_AXI_AWREADY, // AW ready
  input wire [1:0] S_AXI_BRESP, // Write resp
  input wire S_AXI_BVALID, // B valid
  input wire S_AXI_BREADY, // B ready
  input wire [7:0] S_AXI_ARADDR, // Read addr
  input wire S_AXI_ARREADY, // AR ready
  input wire [31:0] S_AXI_RDATA, // Read data
  input wire [1:0] S_AXI_RRESP, // Read resp
  input wire OPS_ALARM, // Ops alarm
  input wire ISUM_ALARM, // Sum alarm
  input wire [2:0] PHASE_ALARM, // Phase alarms
  input wire HOURLY_CURRENT_SUM_ALARM, // Hourly alarm
  input wire SLOW_SWITCHING_FLAG, // Slow flag
  input wire WEAR_CURVE_ALARM // Wear alarm
);
  // ****************************************
  // Helper state and properties
  // ****************************************
  logic [7:0] aw_q;
  logic wip;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // Latch write address; mark a write in flight so a CTRL clear is not a fault
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      aw_q <= 8'h00;
      wip <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) aw_q <= S_AXI_AWADDR;
      if (S_AXI_AWVALID) wip <= 1'b1;
      else if (S_AXI_BVALID && S_AXI_BREADY) wip <= 1'b0;
    end
  end
  a_isum_common: assert property ((|PHASE_ALARM) == ISUM_ALARM)
    else $error("common sum alarm disagrees with phase alarms");
  a_isum_on_open: assert property ($rose(ISUM_ALARM) |-> POS_OFF)
    else $error("sum alarm rose without open breaker");
  a_hour_on_open: assert property ($rose(HOURLY_CURRENT_SUM_ALARM) |-> POS_OFF)
    else $error("hourly alarm rose without open breaker");
  a_ops_on_end: assert property ($rose(OPS_ALARM) |-> POS_ON || POS_OFF)
    else $error("ops alarm rose mid travel");
  a_wear_on_open: assert property ($rose(WEAR_CURVE_ALARM) |-> POS_OFF)
    else $error("wear alarm rose without open breaker");
  a_slow_sticky: assert property (SLOW_SWITCHING_FLAG && !wip && !S_AXI_AWVALID
    && !S_AXI_BVALID |=> SLOW_SWITCHING_FLAG)
    else $error("slow flag dropped without clear");
  a_wear_readable: assert property (S_AXI_ARREADY && S_AXI_ARADDR == 8'h34
    |=> S_AXI_RRESP == 2'b00)
    else $error("wear level read refused");
  a_rd_refused: assert property (S_AXI_ARREADY && S_AXI_ARADDR > 8'h34
    |=> S_AXI_RRESP == 2'b10 && S_AXI_RDATA == 32'h0)
    else $error("read past map not refused");
  a_curve_write: assert property (S_AXI_BVALID && aw_q >= 8'h40 && aw_q <= 8'h64
    |-> S_AXI_BRESP == 2'b00)
    else $error("curve point write refused");
  a_reset_quiet: assert property ($fell(RST) |-> !OPS_ALARM && !WEAR_CURVE_ALARM)
    else $error("alarm high after reset");
endmodule // sgwm_chk
bind sgwm_monitor sgwm_chk u_chk (.*);

// ### tb/sgwm_brk.sv
// Behavioural breaker with position contacts and travel delay
module sgwm_brk (
  input logic clk, // Clock
  input logic rst, // Reset
  input logic trip, // Open command
  input logic close, // Close command
  input logic [31:0] dly, // Travel cycles
  output logic pos_on, // Closed contact
  output logic pos_off // Open contact
);
  logic tq, cq, mov, to_on;
  logic [31:0] cnt;
  // Both contacts low while travelling, as a real breaker shows
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pos_on <= 1'b0;
      pos_off <= 1'b1;
      tq <= 1'b0;
      cq <= 1'b0;
      mov <= 1'b0;
      to_on <= 1'b0;
      cnt <= 32'h0;
    end else begin
      tq <= trip;
      cq <= close;
      if (!mov && trip && !tq && pos_on) begin
        mov <= 1'b1;
        to_on <= 1'b0;
        pos_on <= 1'b0;
        cnt <= 32'h0;
      end else if (!mov && close && !cq && pos_off) begin
        mov <= 1'b1;
        to_on <= 1'b1;
        pos_off <= 1'b0;
        cnt <= 32'h0;
      end else if (mov) begin
        cnt <= cnt + 32'h1;
        if (cnt >= dly) begin
          mov <= 1'b0;
          if (to_on) pos_on <= 1'b1;
          else pos_off <= 1'b1;
        end
      end
    end
  end
endmodule // sgwm_brk

// ### tb/testbench.sv
// Self-checking bench for the switchgear wear monitor
`include "sgwm_consts.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK_SYS = 0, RST = 1, TRIP_CMD = 0, CLOSE_CMD = 0;
  logic [15:0] I_L1 = 0, I_L2 = 0, I_L3 = 0;
  logic [7:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
  logic [31:0] S_AXI_WDATA = 0, brk_dly = 32'h14;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
  logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
  wire POS_ON, POS_OFF, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
  wire S_AXI_ARREADY, S_AXI_RVALID, OPS_ALARM, ISUM_ALARM;
  wire HOURLY_CURRENT_SUM_ALARM, SLOW_SWITCHING_FLAG, WEAR_CURVE_ALARM;
  wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
  wire [31:0] S_AXI_RDATA;
  wire [2:0] PHASE_ALARM;
  logic [31:0] seed = 32'h8B4A, d, ew, eh;
  logic [31:0] es [3];
  logic [15:0] ci [3];
  logic [1:0] r;
  int fail_count = 0, n_checks = 0, cyc = 0;
  localparam logic [31:0] RST_TAB [6] = '{32'h2710, 32'hF4240, 32'h2710, 32'h3E8,
    32'h3E8, 32'hA};
  // Hour shortened so the whole run sits inside one window
  sgwm_monitor #(.HOUR_CYCLES(64'd200000)) dut (.*);
  sgwm_brk brk (.clk(CLK_SYS), .rst(RST), .trip(TRIP_CMD), .close(CLOSE_CMD),
    .dly(brk_dly), .pos_on(POS_ON), .pos_off(POS_OFF));
  // ****************************************
  // Helpers
  // ****************************************
  always #50 CLK_SYS = ~CLK_SYS;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Phase currents kept in one kA step so every phase maps to the same curve point
  function automatic logic [15:0] cur();
    return 16'(32'h7D0 + rnd() % 32'h3E8);
  endfunction
  // Percent consumed by one opening at ka; curve (1,8) to (3,0)
  function automatic logic [31:0] ewear(input int ka);
    int n;
    n = (ka <= 1) ? 8 : (ka > 3) ? 0 : 8 - (ka - 1) * 4;
    return (n == 0) ? 32'h64 : 32'h64 / n;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w;
    @(posedge CLK_SYS);
    {aw, w} = 2'b00;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= v;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    while (!(aw && w)) begin
      @(posedge CLK_SYS);
      if (S_AXI_AWREADY === 1'b1) aw = 1'b1;
      if (S_AXI_WREADY === 1'b1) w = 1'b1;
      if (aw) S_AXI_AWVALID <= 1'b0;
      if (w) S_AXI_WVALID <= 1'b0;
    end
    while (S_AXI_BVALID !== 1'b1) @(posedge CLK_SYS);
    r = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge CLK_SYS);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    while (1) begin
      @(posedge CLK_SYS);
      if (S_AXI_ARREADY === 1'b1) S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID === 1'b1) break;
    end
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  endtask
  // Command held until the contact arrives, then settle past the wear update
  task mv(input logic trp, input logic [31:0] dl);
    @(posedge CLK_SYS);
    brk_dly <= dl;
    if (trp) TRIP_CMD <= 1'b1;
    else CLOSE_CMD <= 1'b1;
    while ((trp ? POS_OFF : POS_ON) !== 1'b1) @(posedge CLK_SYS);
    TRIP_CMD <= 1'b0;
    CLOSE_CMD <= 1'b0;
    repeat (60) @(posedge CLK_SYS);
  endtask
  task give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard well above the one slow travel
  always @(posedge CLK_SYS) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      give_verdict();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge CLK_SYS);
    RST <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(8'(4 * i + 4));
      chk(d, RST_TAB[i]);
    end
    rd(`SGWM_OFF_STATUS);
    chk(d, 32'h0);
    rd(8'h38);
    chk(d, 32'h0);
    chk(r, 2'b10);
    rd(`SGWM_OFF_CURVE);
    chk(r, 2'b10);
    wr(8'h3C, 32'h1);
    chk(r, 2'b10);
    wr(`SGWM_OFF_CTRL, 32'h1);
    wr(`SGWM_OFF_OPS_MAX, 32'h2);
    wr(`SGWM_OFF_ISUM_THR, 32'h1388);
    wr(`SGWM_OFF_IHR_THR, 32'hDAC);
    wr(`SGWM_OFF_T_OPEN, 32'h1);
    wr(`SGWM_OFF_T_CLOSE, 32'h1);
    wr(`SGWM_OFF_NPTS, 32'h2);
    wr(`SGWM_OFF_CURVE, 32'h0001_0008);
    chk(r, 2'b00);
    wr(`SGWM_OFF_CURVE + 8'h4, 32'h0003_0005);
    {ew, eh, es[0], es[1], es[2]} = '0;
    for (int k = 0; k < 2; k++) begin
      mv(1'b0, 32'h14);
      chk(OPS_ALARM, k);
      for (int p = 0; p < 3; p++) ci[p] = cur();
      I_L1 <= ci[0];
      I_L2 <= ci[1];
      I_L3 <= ci[2];
      for (int p = 0; p < 3; p++) es[p] += ci[p];
      eh += (ci[0] > ci[1]) ? ((ci[0] > ci[2]) ? ci[0] : ci[2])
        : ((ci[1] > ci[2]) ? ci[1] : ci[2]);
      ew += ewear(2);
      mv(1'b1, 32'h14);
      rd(`SGWM_OFF_OPS_CNT);
      chk(d, 2 * k + 2);
      for (int p = 0; p < 3; p++) begin
        rd(8'(`SGWM_OFF_SUM_L1 + 4 * p));
        chk(d, es[p]);
      end
      chk(PHASE_ALARM, {es[2] > 32'h1388, es[1] > 32'h1388, es[0] > 32'h1388});
      chk(ISUM_ALARM, (es[0] > 32'h1388) || (es[1] > 32'h1388) || (es[2] > 32'h1388));
      rd(`SGWM_OFF_HR_SUM);
      chk(d, eh);
      chk(HOURLY_CURRENT_SUM_ALARM, eh > 32'hDAC);
      rd(`SGWM_OFF_WEAR);
      chk(d, ew);
      chk({WEAR_CURVE_ALARM, SLOW_SWITCHING_FLAG}, 2'b00);
    end
    mv(1'b0, 32'h61A8);
    chk(SLOW_SWITCHING_FLAG, 1'b1);
    {I_L1, I_L2, I_L3} <= {3{16'h1388}};
    mv(1'b1, 32'h14);
    chk(WEAR_CURVE_ALARM, 1'b1);
    rd(`SGWM_OFF_STATUS);
    chk(d[`SGWM_ST_MAINT], 1'b1);
    wr(`SGWM_OFF_CTRL, 32'h1);
    rd(`SGWM_OFF_OPS_CNT);
    chk(d, 32'h0);
    chk({WEAR_CURVE_ALARM, SLOW_SWITCHING_FLAG}, 2'b00);
    give_verdict();
  end
endmodule // testbench
